// file: inc/sdad_cfg.svh
// Purpose: Named constants for the stall detection and auto-check block
// Assumes: 125 MHz clock
// Notes:   Included by bare name
`ifndef SDAD_CFG_SVH
`define SDAD_CFG_SVH
`define SDAD_CLK_MHZ        125
`define SDAD_BEMF_W         5
`define SDAD_THR_W          4
`define SDAD_TO_W           8
`define SDAD_SP_W           8
`define SDAD_STALL_RUNS     2'h2
`define SDAD_BACKOFF_STEPS  3'h3
`define SDAD_DEAD_MS        2
`define SDAD_DEAD_CYC       (`SDAD_DEAD_MS * 1000 * `SDAD_CLK_MHZ)
`define SDAD_TO_PWM_PER_CNT 3'h4
`define SDAD_SP_US          20
`define SDAD_SP_CYC         (`SDAD_SP_US * `SDAD_CLK_MHZ)
`define SDAD_SP_MAX         8'hff
`endif

// file: inc/sdad_pkg.sv
// Purpose: Types for the stall detection and auto-check block
// Assumes: Nothing
// Notes:   Holds types only
package sdad_pkg;
  typedef enum logic [1:0] {
    SDAD_DG_IDLE = 2'b00,
    SDAD_DG_WAIT = 2'b01,
    SDAD_DG_EVAL = 2'b10
  } sdad_diag_e;
endpackage : sdad_pkg

// file: core/sdad_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Asynchronous input
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sdad_sync (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Output only changes once stages two and three agree
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        sync_out <= s3_r;
    end
  end
endmodule : sdad_sync
`default_nettype wire

// file: core/sdad_core.sv
// Purpose: Back-EMF sampling, stall and hold-motion detection, auto open/short check
// Assumes: Sample strobes and comparator results arrive from same-clock logic
// Notes:   Direction pin comes from outside and is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "sdad_cfg.svh"
// What this block does
// - Sample back-EMF during zero crossing, drop samples taken in other coil's on phase
// - Store each kept sample as a 5-bit back-EMF code
// - Flag result ready when a conversion completes
// - Normal mode exposes only the last sample before zero crossing ends
// - Continuous mode updates the value with every kept sample
// - Timeout forces a sample; units of four PWM periods; zero disables
// - At zero-crossing end compare the last sample with the threshold
// - Threshold zero disables stall detection
// - Two successive low crossings set stall, assert error, back off 135 degrees
// - Reading status register 1 clears stall and releases error
// - After stall clear ignore steps until direction changes
// - In hold at single-coil full step, back-EMF at or above threshold flags motion
// - No hold motion detection when hold current is zero
// - Measure and detect only while step period is within limit
// - Step period counts 20 us per count, saturating at full scale
// - Set sign flag on wrong polarity; report sign and coil
// - Threshold index picks a level linear in index, scaled by gain select
// - Auto check after power-up and on enable rise when enabled
// - Any short clears bridge drive and blocks normal mode
// - Auto check waits 2 ms dead time, aborts on deep under-voltage
// - Result ready gated by its enable joins the error output
// - Encode short and open summary plus per-transistor short bits
module sdad_core #(
  parameter int unsigned DEAD_CYC = `SDAD_DEAD_CYC,
  parameter int unsigned SP_CYC   = `SDAD_SP_CYC
) (
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    pwm_period_in,
  input  wire logic                    x_target_zero_in,
  input  wire logic                    y_target_zero_in,
  input  wire logic                    x_pwm_on_in,
  input  wire logic                    y_pwm_on_in,
  input  wire logic                    sample_strobe_in,
  input  wire logic [`SDAD_BEMF_W-1:0] sample_code_in,
  input  wire logic                    sample_sign_bad_in,
  input  wire logic                    step_pulse_in,
  input  wire logic                    dir_pin_in,
  input  wire logic                    hold_mode_in,
  input  wire logic                    full_step_single_in,
  input  wire logic [3:0]              standstill_current_level_in,
  input  wire logic                    continuous_sampling_enable_in,
  input  wire logic [`SDAD_THR_W-1:0]  stall_threshold_in,
  input  wire logic [`SDAD_TO_W-1:0]   stall_timeout_in,
  input  wire logic [`SDAD_SP_W-1:0]   step_period_limit_in,
  input  wire logic                    back_emf_scale_select_in,
  input  wire logic                    back_emf_irq_enable_in,
  input  wire logic                    status1_read_in,
  input  wire logic                    bemf_read_in,
  input  wire logic                    fault_read_in,
  input  wire logic                    bridge_drive_set_in,
  input  wire logic                    bridge_drive_clr_in,
  input  wire logic                    autocheck_on_enable_in,
  input  wire logic                    uv3_in,
  input  wire logic                    x_open_sense_in,
  input  wire logic [3:0]              x_short_sense_in,
  output var  logic [`SDAD_BEMF_W-1:0] back_emf_value_out,
  output var  logic                    back_emf_sign_out,
  output var  logic                    back_emf_coil_out,
  output var  logic                    back_emf_result_ready_out,
  output var  logic                    stall_out,
  output var  logic [`SDAD_SP_W-1:0]   step_period_measure_out,
  output var  logic [4:0]              threshold_level_out,
  output var  logic                    step_accept_out,
  output var  logic                    backoff_step_out,
  output var  logic                    bridge_drive_on_out,
  output var  logic                    autocheck_busy_out,
  output var  logic                    short_flag_out,
  output var  logic                    open_flag_out,
  output var  logic                    x_coil_open_flag_out,
  output var  logic                    x_pos_low_side_short_out,
  output var  logic                    x_neg_low_side_short_out,
  output var  logic                    x_pos_high_side_short_out,
  output var  logic                    x_neg_high_side_short_out,
  output var  logic                    error_out_n
);
  typedef struct packed {
    logic [`SDAD_BEMF_W-1:0] val;
    logic                    sgn;
    logic                    coil;
    logic [`SDAD_BEMF_W-1:0] last;
    logic                    have;
    logic                    rdy;
    logic                    stall;
    logic [1:0]              low_cnt;
    logic                    dir_lock;
    logic                    dir_seen;
    logic [2:0]              back_cnt;
    logic                    zc_x;
    logic                    zc_y;
    logic                    timed;
    logic [1:0]              pwm_div;
    logic [`SDAD_TO_W-1:0]   to_cnt;
    logic [31:0]             sp_tick;
    logic [`SDAD_SP_W-1:0]   sp_run;
    logic [`SDAD_SP_W-1:0]   sp;
    logic                    drive;
    logic                    boot;
    sdad_pkg::sdad_diag_e    dg;
    logic [31:0]             dg_cnt;
    logic                    opn;
    logic [3:0]              shr;
  } sdad_state_s;

  sdad_state_s st_r;
  sdad_state_s st_nxt;
  logic        dir_sync;

  // Direction pin comes from outside the clock domain
  sdad_sync u_dir_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (dir_pin_in),
    .sync_out   (dir_sync)
  );

  // Upper bits of the code against the threshold
  function automatic logic below_thr(input logic [`SDAD_BEMF_W-1:0] code,
                                     input logic [`SDAD_THR_W-1:0] thr);
    below_thr = code[`SDAD_BEMF_W-1:1] < thr;
  endfunction : below_thr

  logic zc_any;
  logic zc_prev;
  logic zc_end;
  logic speed_ok;
  logic keep;
  logic to_hit;
  logic do_eval;
  logic thr_on;
  logic hold_watch;
  logic dg_done;

  // Combinational helpers for the sampling window
  always_comb
  begin
    zc_any     = x_target_zero_in | y_target_zero_in;
    zc_prev    = st_r.zc_x | st_r.zc_y;
    zc_end     = (st_r.zc_x & ~x_target_zero_in) | (st_r.zc_y & ~y_target_zero_in);
    speed_ok   = st_r.sp <= step_period_limit_in;
    // Discard samples while the opposite coil's switches conduct
    keep       = sample_strobe_in & speed_ok &
                 ((x_target_zero_in & ~y_pwm_on_in) | (y_target_zero_in & ~x_pwm_on_in));
    to_hit     = (stall_timeout_in != 8'h00) & zc_prev & ~st_r.timed &
                 pwm_period_in & (st_r.pwm_div == 2'h3) &
                 (st_r.to_cnt + 8'h01 >= stall_timeout_in);
    do_eval    = (zc_end | to_hit) & st_r.have & speed_ok;
    thr_on     = stall_threshold_in != 4'h0;
    hold_watch = hold_mode_in & full_step_single_in &
                 (standstill_current_level_in != 4'h0);
    dg_done    = st_r.dg_cnt >= DEAD_CYC - 1;
  end

  // Next state of the whole block
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.zc_x = x_target_zero_in;
    st_nxt.zc_y = y_target_zero_in;

    // Timeout counter in units of four PWM periods
    if (!zc_any)
    begin
      st_nxt.pwm_div = 2'h0;
      st_nxt.to_cnt  = 8'h00;
      st_nxt.timed   = 1'b0;
    end
    else if (pwm_period_in)
    begin
      st_nxt.pwm_div = st_r.pwm_div + 2'h1;
      if (st_r.pwm_div == 2'h3 && st_r.to_cnt != 8'hff)
        st_nxt.to_cnt = st_r.to_cnt + 8'h01;
    end

    // Sample capture; continuous mode shows every kept sample
    if (keep)
    begin
      st_nxt.last = sample_code_in;
      st_nxt.have = 1'b1;
      st_nxt.sgn  = sample_sign_bad_in;
      st_nxt.coil = y_target_zero_in & ~x_target_zero_in;
      if (continuous_sampling_enable_in)
      begin
        st_nxt.val = sample_code_in;
        st_nxt.rdy = 1'b1;
      end
    end

    // Software read clears ready; a new result in the same cycle wins
    if (bemf_read_in && !(keep && continuous_sampling_enable_in))
      st_nxt.rdy = 1'b0;

    // Status read clears stall first, so a stall raised below in this cycle wins
    if (status1_read_in && st_r.stall)
    begin
      st_nxt.stall    = 1'b0;
      st_nxt.dir_lock = 1'b1;
      st_nxt.dir_seen = dir_sync;
    end

    // Evaluation at the end of the crossing or on timeout
    if (do_eval)
    begin
      st_nxt.val  = st_r.last;
      st_nxt.rdy  = 1'b1;
      st_nxt.have = 1'b0;
      if (to_hit)
        st_nxt.timed = 1'b1;
      if (thr_on && !hold_mode_in)
      begin
        if (below_thr(st_r.last, stall_threshold_in))
        begin
          st_nxt.low_cnt = st_r.low_cnt + 2'h1;
          if (st_r.low_cnt + 2'h1 >= `SDAD_STALL_RUNS)
          begin
            st_nxt.stall    = 1'b1;
            st_nxt.low_cnt  = 2'h0;
            st_nxt.back_cnt = `SDAD_BACKOFF_STEPS;
          end
        end
        else
          st_nxt.low_cnt = 2'h0;
      end
      else if (thr_on && hold_watch && !below_thr(st_r.last, stall_threshold_in))
        st_nxt.stall = 1'b1;
    end
    else if (zc_end)
      st_nxt.have = 1'b0;

    // Back-off steps run in opposite direction, one per PWM period
    if (st_r.back_cnt != 3'h0 && pwm_period_in)
      st_nxt.back_cnt = st_r.back_cnt - 3'h1;
    if (st_r.dir_lock && dir_sync != st_r.dir_seen)
      st_nxt.dir_lock = 1'b0;

    // Step period measurement, saturating
    if (st_r.sp_tick >= SP_CYC - 1)
    begin
      st_nxt.sp_tick = 32'h0;
      if (st_r.sp_run != `SDAD_SP_MAX)
        st_nxt.sp_run = st_r.sp_run + 8'h01;
    end
    else
      st_nxt.sp_tick = st_r.sp_tick + 32'h1;
    if (step_pulse_in)
    begin
      st_nxt.sp      = st_r.sp_run;
      st_nxt.sp_run  = 8'h00;
      st_nxt.sp_tick = 32'h0;
    end

    // Bridge drive and automatic check sequencing
    if (bridge_drive_clr_in)
      st_nxt.drive = 1'b0;
    else if (bridge_drive_set_in && !st_r.drive)
    begin
      st_nxt.drive = 1'b1;
      if (autocheck_on_enable_in && !uv3_in)
      begin
        st_nxt.dg     = sdad_pkg::SDAD_DG_WAIT;
        st_nxt.dg_cnt = 32'h0;
      end
    end
    if (fault_read_in)
    begin
      st_nxt.opn = 1'b0;
      st_nxt.shr = 4'h0;
    end
    case (st_r.dg)
      sdad_pkg::SDAD_DG_IDLE:
      begin
        if (st_r.boot && !uv3_in)
        begin
          st_nxt.boot   = 1'b0;
          st_nxt.dg     = sdad_pkg::SDAD_DG_WAIT;
          st_nxt.dg_cnt = 32'h0;
        end
      end
      sdad_pkg::SDAD_DG_WAIT:
      begin
        st_nxt.dg_cnt = st_r.dg_cnt + 32'h1;
        if (uv3_in)
          st_nxt.dg = sdad_pkg::SDAD_DG_IDLE;
        else if (dg_done)
          st_nxt.dg = sdad_pkg::SDAD_DG_EVAL;
      end
      sdad_pkg::SDAD_DG_EVAL:
      begin
        st_nxt.dg  = sdad_pkg::SDAD_DG_IDLE;
        st_nxt.opn = x_open_sense_in;
        st_nxt.shr = x_short_sense_in;
        if (x_short_sense_in != 4'h0)
          st_nxt.drive = 1'b0;
      end
      default:
        st_nxt.dg = sdad_pkg::SDAD_DG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r      <= '0;
      st_r.boot <= 1'b1;
      st_r.dg   <= sdad_pkg::SDAD_DG_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs from state and live inputs; error output is low when stall, short or open is set, or ready with its enable
  always_comb
  begin
    back_emf_value_out        = st_r.val;
    back_emf_sign_out         = st_r.sgn;
    back_emf_coil_out         = st_r.coil;
    back_emf_result_ready_out = st_r.rdy;
    stall_out                 = st_r.stall;
    step_period_measure_out   = st_r.sp;
    threshold_level_out       = back_emf_scale_select_in ?
                                {stall_threshold_in, 1'b0} : {1'b0, stall_threshold_in};
    step_accept_out           = step_pulse_in & ~st_r.stall & ~st_r.dir_lock &
                                (st_r.back_cnt == 3'h0);
    backoff_step_out          = (st_r.back_cnt != 3'h0) & pwm_period_in;
    // Drive only in normal mode: never while a check runs
    bridge_drive_on_out       = st_r.drive & (st_r.dg == sdad_pkg::SDAD_DG_IDLE) &
                                ~st_r.boot;
    autocheck_busy_out        = st_r.dg != sdad_pkg::SDAD_DG_IDLE;
    short_flag_out            = st_r.shr != 4'h0;
    open_flag_out             = st_r.opn;
    x_coil_open_flag_out      = st_r.opn;
    x_pos_low_side_short_out  = st_r.shr[3];
    x_neg_low_side_short_out  = st_r.shr[2];
    x_pos_high_side_short_out = st_r.shr[1];
    x_neg_high_side_short_out = st_r.shr[0];
    error_out_n               = ~(st_r.stall | (st_r.shr != 4'h0) | st_r.opn |
                                  (back_emf_irq_enable_in & st_r.rdy));
  end

  a_stall_err: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r.stall |-> !error_out_n) else $error("stall without error output");
  a_stall_clr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r.stall && status1_read_in && !do_eval) |=> !st_r.stall) else $error("stall not cleared");
  a_dir_lock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r.dir_lock |-> !step_accept_out) else $error("step accepted while locked");
  a_thr_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!thr_on && !st_r.stall && !status1_read_in) |=> !$rose(st_r.stall))
    else $error("stall with zero threshold");
  a_norm_val: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!continuous_sampling_enable_in && !do_eval) |=> $stable(st_r.val))
    else $error("value moved outside evaluation");
  a_cont_val: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (keep && continuous_sampling_enable_in && !do_eval) |=> st_r.val == $past(sample_code_in))
    else $error("continuous value not updated");
  a_rdy_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_eval |=> st_r.rdy) else $error("ready not set");
  a_short_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r.dg == sdad_pkg::SDAD_DG_EVAL && x_short_sense_in != 4'h0) |=> !bridge_drive_on_out)
    else $error("drive on after short");
  a_uv_abort: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r.dg == sdad_pkg::SDAD_DG_WAIT && uv3_in) |=> st_r.dg == sdad_pkg::SDAD_DG_IDLE)
    else $error("check not aborted");
endmodule : sdad_core
`default_nettype wire

// file: dv/sdad_motor_model.sv
// Purpose: Motor-side model: PWM ticks, zero-crossing phases, back-EMF samples
// Assumes: Runs on the block's clock; outputs change just after the rising edge
// Notes:   Sample lines carry inverted data between strobes so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module sdad_motor_model (
  input  wire logic       clk_in,
  input  wire logic       x_zc_req_in,
  input  wire logic       y_zc_req_in,
  input  wire logic       other_on_in,
  input  wire logic [4:0] code_in,
  input  wire logic       sign_bad_in,
  output var  logic       pwm_period_out,
  output var  logic       x_target_zero_out,
  output var  logic       y_target_zero_out,
  output var  logic       x_pwm_on_out,
  output var  logic       y_pwm_on_out,
  output var  logic       sample_strobe_out,
  output var  logic [4:0] sample_code_out,
  output var  logic       sample_sign_bad_out
);
  logic [2:0] tick_r;
  // Known start values; the block sees no unknowns before the first edge
  initial
  begin
    tick_r = 3'h0;
    {pwm_period_out, x_target_zero_out, y_target_zero_out} = 3'h0;
    {x_pwm_on_out, y_pwm_on_out, sample_strobe_out} = 3'h0;
    sample_code_out = 5'h00;
    sample_sign_bad_out = 1'b0;
  end
  // PWM tick every 8 cycles; a sample on every second cycle of a zero crossing
  always @(posedge clk_in)
  begin
    tick_r              <= tick_r + 3'h1;
    pwm_period_out      <= (tick_r == 3'h7);
    x_target_zero_out   <= x_zc_req_in;
    y_target_zero_out   <= y_zc_req_in;
    x_pwm_on_out        <= y_zc_req_in & other_on_in;
    y_pwm_on_out        <= x_zc_req_in & other_on_in;
    sample_strobe_out   <= (x_zc_req_in | y_zc_req_in) & tick_r[0];
    sample_code_out     <= tick_r[0] ? code_in : ~sample_code_out;
    sample_sign_bad_out <= tick_r[0] ? sign_bad_in : ~sample_sign_bad_out;
  end
endmodule : sdad_motor_model
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the stall detection and auto-check block
// Assumes: 125 MHz clock; dead time and step unit shortened by parameters
// Notes:   Inputs change on the falling edge or 1 ns after it; every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, rst, zx, zy, oth, sgn, pwm, xz, yz, xon, yon, stb, sb, step, dir;
  logic       hold, fss, cont, gain, irq, s1rd, brd, frd, dset, dclr, aen, xopen, uv;
  logic       sign, coil, rdy, stall, acc, bko, drv, busy, shf, opf, xo, errn;
  logic [4:0] cd, code, val, tlev;
  logic [3:0] lvl, thr, xsh, s;
  logic [7:0] spm, lim, sto;
  int         errors, tests_run, i, n;

  sdad_motor_model motor (.clk_in(clk), .x_zc_req_in(zx), .y_zc_req_in(zy),
    .other_on_in(oth), .code_in(cd), .sign_bad_in(sgn), .pwm_period_out(pwm),
    .x_target_zero_out(xz), .y_target_zero_out(yz), .x_pwm_on_out(xon),
    .y_pwm_on_out(yon), .sample_strobe_out(stb), .sample_code_out(code),
    .sample_sign_bad_out(sb));

  // Short dead time and step unit keep the run brief
  sdad_core #(.DEAD_CYC(20), .SP_CYC(4)) DUT (.clk_in(clk), .sys_rst_in(rst),
    .pwm_period_in(pwm), .x_target_zero_in(xz), .y_target_zero_in(yz), .x_pwm_on_in(xon),
    .y_pwm_on_in(yon), .sample_strobe_in(stb), .sample_code_in(code),
    .sample_sign_bad_in(sb), .step_pulse_in(step), .dir_pin_in(dir), .hold_mode_in(hold),
    .full_step_single_in(fss), .standstill_current_level_in(lvl),
    .continuous_sampling_enable_in(cont), .stall_threshold_in(thr),
    .stall_timeout_in(sto), .step_period_limit_in(lim), .back_emf_scale_select_in(gain),
    .back_emf_irq_enable_in(irq), .status1_read_in(s1rd), .bemf_read_in(brd),
    .fault_read_in(frd), .bridge_drive_set_in(dset), .bridge_drive_clr_in(dclr),
    .autocheck_on_enable_in(aen), .uv3_in(uv), .x_open_sense_in(xopen),
    .x_short_sense_in(xsh), .back_emf_value_out(val), .back_emf_sign_out(sign),
    .back_emf_coil_out(coil), .back_emf_result_ready_out(rdy), .stall_out(stall),
    .step_period_measure_out(spm), .threshold_level_out(tlev), .step_accept_out(acc),
    .backoff_step_out(bko), .bridge_drive_on_out(drv), .autocheck_busy_out(busy),
    .short_flag_out(shf), .open_flag_out(opf), .x_coil_open_flag_out(xo),
    .x_pos_low_side_short_out(s[3]), .x_neg_low_side_short_out(s[2]),
    .x_pos_high_side_short_out(s[1]), .x_neg_high_side_short_out(s[0]),
    .error_out_n(errn));

  // 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      errors++;
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Bounded wait on the check-busy flag; running out ends the run
  task automatic wait_busy(input logic want);
    for (int k = 0; k < 80 && busy !== want; k++)
      cyc(1);
    if (busy !== want)
    begin
      errors++;
      conclude();
    end
  endtask : wait_busy

  // One zero crossing: first code, then the code that should be kept last
  task automatic zc(input logic on_y, input logic [4:0] a, input logic [4:0] b);
    cd = a;
    zx = !on_y;
    zy = on_y;
    cyc(6);
    cd = b;
    cyc(6);
    zx = 1'b0;
    zy = 1'b0;
  endtask : zc

  task automatic pulse_read(input int which);
    {s1rd, brd, frd} = (which == 0) ? 3'b100 : (which == 1) ? 3'b010 : 3'b001;
    cyc(1);
    {s1rd, brd, frd} = 3'b000;
    cyc(1);
  endtask : pulse_read

  initial
  begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    {zx, zy, oth, sgn, step, dir, hold, fss, cont, gain, irq} = 11'h000;
    {s1rd, brd, frd, dset, dclr, aen, xopen} = 7'h00;
    {cd, lvl, thr, xsh} = 17'h00000;
    {lim, sto, uv} = 17'h1fe00;
    cyc(4);
    rst = 1'b0;
    // Power-up check runs by itself after reset
    cyc(2);
    chk("busy_start", busy, 1'b1);
    cyc(15);
    chk("busy_dead", busy, 1'b1);
    wait_busy(1'b0);
    chk("pu_short", shf, 1'b0);
    chk("pu_errn", errn, 1'b1);
    // Threshold level is index times step, step doubled by the scale select
    for (i = 0; i < 32; i++)
    begin
      {gain, thr} = i[4:0];
      cyc(1);
      chk("thr_level", tlev, thr * (gain ? 8'h02 : 8'h01));
    end
    // Normal mode keeps the last sample; sign, coil and ready follow it
    {gain, thr, irq, sgn} = 7'h03;
    zc(1'b1, 5'h05, 5'h0b);
    cyc(4);
    chk("val_last", val, 5'h0b);
    chk("coil_y", coil, 1'b1);
    chk("sign", sign, 1'b1);
    chk("ready", rdy, 1'b1);
    chk("errn_rdy", errn, 1'b0);
    pulse_read(1);
    chk("errn_clr", errn, 1'b1);
    // Continuous mode follows samples while the crossing lasts
    {irq, sgn, cont} = 3'b001;
    cd = 5'h09;
    zx = 1'b1;
    cyc(5);
    chk("val_cont", val, 5'h09);
    zx = 1'b0;
    cyc(4);
    // Samples while the other coil is switching are dropped
    oth = 1'b1;
    zc(1'b0, 5'h1a, 5'h1a);
    cyc(4);
    chk("val_drop", val, 5'h09);
    oth = 1'b0;
    cont = 1'b0;
    // Two low crossings on alternate coils trip stall and back off
    thr = 4'h8;
    zc(1'b0, 5'h11, 5'h11);
    cyc(4);
    zc(1'b0, 5'h1f, 5'h0f);
    cyc(4);
    chk("stall_one", stall, 1'b0);
    zc(1'b1, 5'h03, 5'h03);
    n = 0;
    for (i = 0; i < 48; i++)
    begin
      cyc(1);
      n = n + int'(bko);
    end
    chk("stall_two", stall, 1'b1);
    chk("errn_stall", errn, 1'b0);
    chk("backoff_n", n[7:0], 8'h03);
    pulse_read(0);
    chk("stall_clr", stall, 1'b0);
    chk("errn_rel", errn, 1'b1);
    step = 1'b1;
    #1;
    chk("step_lock", acc, 1'b0);
    step = 1'b0;
    dir = 1'b1;
    cyc(8);
    step = 1'b1;
    #1;
    chk("step_ok", acc, 1'b1);
    cyc(1);
    step = 1'b0;
    // Next step 42 cycles later: ten whole units of four cycles
    cyc(41);
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    chk("step_period", spm, 8'h0a);
    // Step period above the limit blocks sampling and evaluation
    {thr, lim} = 12'h005;
    zc(1'b0, 5'h1c, 5'h1c);
    cyc(4);
    chk("val_slow", val, 5'h03);
    // A crossing that never ends is evaluated at the timeout
    {lim, sto} = 16'hff01;
    cd = 5'h15;
    zx = 1'b1;
    cyc(48);
    chk("val_tout", val, 5'h15);
    zx = 1'b0;
    cyc(4);
    sto = 8'h00;
    // Threshold zero switches stall detection off
    thr = 4'h0;
    zc(1'b0, 5'h01, 5'h01);
    cyc(4);
    zc(1'b1, 5'h01, 5'h01);
    cyc(4);
    chk("stall_off", stall, 1'b0);
    // Hold motion at a single-coil full step; code equal to the threshold counts
    {thr, hold, fss, lvl} = 10'h230;
    zc(1'b0, 5'h1f, 5'h1f);
    cyc(4);
    chk("hold_zero_i", stall, 1'b0);
    lvl = 4'h4;
    zc(1'b0, 5'h10, 5'h10);
    cyc(4);
    chk("hold_motion", stall, 1'b1);
    chk("errn_motion", errn, 1'b0);
    pulse_read(0);
    {hold, fss, thr} = 6'h00;
    // Enable check with a top-side short on the negative pin and an open coil
    {aen, xopen, xsh} = 6'h31;
    dset = 1'b1;
    cyc(1);
    dset = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    cyc(2);
    chk("drv_off", drv, 1'b0);
    chk("sum_flags", {shf, opf, xo}, 3'h7);
    chk("short_bits", s, 4'h1);
    chk("errn_short", errn, 1'b0);
    {xopen, xsh} = 5'h00;
    pulse_read(2);
    chk("flags_clr", {shf, opf, xo, s}, 7'h00);
    // Controller turns drive off then on again before the next check
    dclr = 1'b1;
    cyc(1);
    dclr = 1'b0;
    dset = 1'b1;
    cyc(1);
    dset = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    cyc(2);
    chk("drv_on", drv, 1'b1);
    // Deep under-voltage cuts a running check short
    dclr = 1'b1;
    cyc(1);
    dclr = 1'b0;
    dset = 1'b1;
    cyc(1);
    {dset, uv} = 2'b01;
    cyc(2);
    chk("uv_abort", busy, 1'b0);
    uv = 1'b0;
    conclude();
  end
endmodule : tb
`default_nettype wire
